/* bench/charge_time_chk.sv */
// Purpose: Port level checks of the charge time unit
// Assumes: Bound into charge_time_unit, one clock domain
// Notes: Shadows follow software writes only, never hardware sets
`timescale 1ns/10ps
module charge_time_chk (
   input wire logic mclk,
   input wire logic reset,
   input wire logic ce,
   input wire charge_time_pkg::addr_t reg_addr,
   input wire charge_time_pkg::byte_t reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire charge_time_pkg::byte_t reg_rdata,
   input wire charge_time_pkg::analog_ctrl_s analog_ctrl,
   input wire logic irq
);
   charge_time_pkg::byte_t sh_high; // High control as written
   charge_time_pkg::byte_t sh_cur; // Current control as written
   logic sh_ien; // Interrupt enable as written
   logic wr_ok; // Write accepted this edge
   logic wr_low; // Accepted write to the low control
   assign wr_ok = ce && reg_write;
   assign wr_low = wr_ok && reg_addr == charge_time_pkg::ADDR_CTRL_LOW;

   // Shadow registers, frozen with ce like the design
   always_ff @(posedge mclk) begin
      if (reset) begin
         sh_high <= 8'h00;
         sh_cur <= 8'h00;
         sh_ien <= 1'b0;
      end else if (wr_ok) begin
         if (reg_addr == charge_time_pkg::ADDR_CTRL_HIGH) sh_high <= reg_wdata;
         if (reg_addr == charge_time_pkg::ADDR_CURRENT) sh_cur <= reg_wdata;
         if (reg_addr == charge_time_pkg::ADDR_IRQ_ENABLES) sh_ien <= reg_wdata[2];
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   property p_both_off;
      wr_low && reg_wdata[1:0] == 2'h3 |=> !analog_ctrl.current_on;
   endproperty
   a_both_off: assert property (p_both_off) else $error("current on with both flags set");
   property p_one_on;
      wr_low && ^reg_wdata[1:0] && sh_high[7] && !sh_high[3] |=> analog_ctrl.current_on;
   endproperty
   a_one_on: assert property (p_one_on) else $error("single flag write left current off");
   property p_gate;
      !sh_high[7] |-> !analog_ctrl.current_on;
   endproperty
   a_gate: assert property (p_gate) else $error("current on with unit disabled");
   property p_mode;
      analog_ctrl.adc_connect == (sh_high[7] && !sh_high[4]) && analog_ctrl.comp_connect == (sh_high[7] && sh_high[4]);
   endproperty
   a_mode: assert property (p_mode) else $error("mode connection wrong");
   property p_trim;
      analog_ctrl.current_range_sel == sh_cur[1:0] && analog_ctrl.current_trim == sh_cur[7:2];
   endproperty
   a_trim: assert property (p_trim) else $error("range or trim fields wrong");
   property p_disch;
      analog_ctrl.discharge == sh_high[1];
   endproperty
   a_disch: assert property (p_disch) else $error("discharge does not follow its bit");
   property p_irq_set;
      $fell(analog_ctrl.current_on) && sh_ien |-> irq;
   endproperty
   a_irq_set: assert property (p_irq_set) else $error("no interrupt at current off");
   property p_irq_mask;
      !sh_ien |-> !irq;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("interrupt while disabled");
   property p_rd_high;
      ce && reg_read && reg_addr == charge_time_pkg::ADDR_CTRL_HIGH
         |=> reg_rdata == ($past(sh_high) & charge_time_pkg::CTRL_HIGH_MASK);
   endproperty
   a_rd_high: assert property (p_rd_high) else $error("high control readback wrong");
   property p_quiet;
      ce && !reg_write && !(sh_high[7] && sh_high[3]) |=> $stable(analog_ctrl.current_on);
   endproperty
   a_quiet: assert property (p_quiet) else $error("current moved with edges disarmed");

   // Main scenarios reached
   c_irq: cover property (irq);
   c_on: cover property ($rose(analog_ctrl.current_on));
   c_comp: cover property (analog_ctrl.comp_connect);
endmodule // charge_time_chk

bind charge_time_unit charge_time_chk chk_u (.mclk(mclk), .reset(reset), .ce(ce), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .analog_ctrl(analog_ctrl), .irq(irq));

/* bench/charge_time_unit_bench.sv */
// Purpose: Self-checking bench of the charge time unit
// Assumes: Register map and codes of charge_time_pkg
// Notes: Sources come from edge_source_model, toggled by index
`timescale 1ns/10ps
module charge_time_unit_bench;
   localparam charge_time_pkg::addr_t H = charge_time_pkg::ADDR_CTRL_HIGH;
   localparam charge_time_pkg::addr_t L = charge_time_pkg::ADDR_CTRL_LOW;
   localparam charge_time_pkg::addr_t IF3 = charge_time_pkg::ADDR_IRQ_FLAGS;
   localparam charge_time_pkg::addr_t IE3 = charge_time_pkg::ADDR_IRQ_ENABLES;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic ce = 1'b1;
   charge_time_pkg::addr_t reg_addr = 3'h0;
   charge_time_pkg::byte_t reg_wdata = 8'h00;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   charge_time_pkg::byte_t reg_rdata;
   charge_time_pkg::analog_ctrl_s ac;
   logic irq;
   logic [4:0] fire = 5'h00; // Toggle requests to the sources
   logic [4:0] level; // Source levels
   int num_errors = 0;
   int n_checks = 0;
   int cycles = 0;
   // Readback of an all-ones write, indices 0 to 5
   charge_time_pkg::byte_t ff_back [6] = '{8'h9E, 8'hFF, 8'hFF, 8'h00, 8'h04, 8'h00};

   always #5 mclk = ~mclk;

   edge_source_model src_u (.mclk(mclk), .reset(reset), .fire(fire), .level(level));
   charge_time_unit dut_u (.mclk(mclk), .reset(reset), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .edge_pin_one(level[0]),
      .edge_pin_two(level[1]), .timer_edge(level[2]), .compare_edge(level[3]),
      .comparator_two_out(level[4]), .analog_ctrl(ac), .irq(irq));

   // Compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One-cycle write; outputs settled on return
   task automatic wr(input charge_time_pkg::addr_t a, input charge_time_pkg::byte_t d);
      @(posedge mclk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_write <= 1'b0;
      #1;
   endtask

   // One-cycle read; data only stand in the following cycle
   task automatic rd(input charge_time_pkg::addr_t a, input charge_time_pkg::byte_t exp);
      @(posedge mclk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_read <= 1'b0;
      #1;
      check(reg_rdata, exp);
   endtask

   // Toggle one source, then allow for pin synchronisers
   task automatic pulse(input int i);
      @(posedge mclk);
      fire <= 5'h01 << i;
      @(posedge mclk);
      fire <= 5'h00;
      repeat (4) @(posedge mclk);
      #1;
   endtask

   // Verdict
   task automatic end_of_test();
      $display("checks=%0d errors=%0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Hang guard, run needs well under 1000 cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         end_of_test();
      end
   end

   initial begin
      repeat (3) @(posedge mclk);
      reset <= 1'b0;
      for (int i = 0; i < 6; i++) rd(i[2:0], 8'h00);
      // Access kinds, unmapped index and write-one-clear
      for (int i = 0; i < 6; i++) begin
         wr(i[2:0], 8'hFF);
         rd(i[2:0], ff_back[i]);
         wr(i[2:0], 8'h00);
      end
      // Writes are ignored while ce is low
      @(posedge mclk) ce <= 1'b0;
      wr(H, 8'h80);
      @(posedge mclk) ce <= 1'b1;
      rd(H, 8'h00);
      // Software steering of the flags, with and without enable
      wr(H, 8'h80);
      wr(IE3, 8'h04);
      wr(L, 8'h01);
      check(ac.current_on, 1'b1);
      wr(L, 8'h03);
      check(ac.current_on, 1'b0);
      check(irq, 1'b1);
      rd(IF3, 8'h04);
      wr(IF3, 8'h04);
      check(irq, 1'b0);
      wr(IE3, 8'h00);
      wr(L, 8'h02);
      wr(L, 8'h00);
      check(irq, 1'b0);
      rd(IF3, 8'h04);
      wr(IF3, 8'h04);
      // Timer and compare edges, order on, falling polarity
      wr(charge_time_pkg::ADDR_CURRENT, 8'h5A);
      check(ac.current_range_sel, 2'h2);
      check(ac.current_trim, 6'h16);
      wr(L, 8'h44);
      wr(H, 8'h8C);
      pulse(3);
      rd(L, 8'h44);
      pulse(2);
      check(ac.current_on, 1'b1);
      pulse(3);
      rd(L, 8'h45);
      pulse(3);
      rd(L, 8'h47);
      check(ac.current_on, 1'b0);
      check(ac.adc_connect, 1'b1);
      wr(L, 8'h44);
      // Pin one feeds both edges, rising polarity, order off;
      // selects move only while disarmed, since a level step
      // at the source mux would read as an edge
      wr(H, 8'h80);
      wr(L, 8'hF0);
      wr(H, 8'h88);
      pulse(0);
      rd(L, 8'hF0);
      pulse(0);
      rd(L, 8'hF3);
      // Delay mode, comparator two sets edge two
      wr(H, 8'h98);
      check(ac.comp_connect, 1'b1);
      wr(L, 8'h01);
      pulse(4);
      rd(L, 8'h03);
      // Pin two on its own select, falling polarity
      wr(L, 8'h01);
      pulse(1);
      rd(L, 8'h03);
      // Discharge switch
      wr(H, 8'h02);
      check(ac.discharge, 1'b1);
      wr(H, 8'h00);
      check(ac.discharge, 1'b0);
      end_of_test();
   end
endmodule // charge_time_unit_bench

/* bench/edge_source_model.sv */
// Purpose: Edge sources, timer, compare unit and comparator two
// Assumes: One toggle request bit per source, mclk domain
// Notes: Pins, timer and compare idle high, comparator idles low
`timescale 1ns/10ps
module edge_source_model (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [4:0] fire,
   output logic [4:0] level = 5'h0F
);
   // Bit 0 pin one, 1 pin two, 2 timer, 3 compare, 4 comparator
   always @(posedge mclk) begin
      if (reset) begin
         level <= 5'h0F;
      end else begin
         // A toggle is one transition, so the bench picks the direction
         level <= level ^ fire;
      end
   end
endmodule // edge_source_model

/* logic/charge_time_unit.sv */
// Purpose: Edge control, current source gating and interrupt of the
//    charge time unit
// Assumes: Plain register port, single 100 MHz mclk, sync reset
// Notes: Edge flags gate a constant current source for the converter
//    or the comparator; software and hardware both move the flags
//
// Notes on behaviour
// [RULE1] Current on only while exactly one flag set
// [RULE2] Software clears both flags before next measurement
// [RULE3] Software writes to flags steer current source
// [RULE4] Interrupt flag set when current turns off
// [RULE5] Interrupt output needs flag and enable bit
// [RULE6] Without ordering, software reads flags for last edge
// [RULE7] Order enable makes edge one precede edge two
// [RULE8] Current register: range bits 1:0, trim 7:2
// [RULE9] Low register: source selects at 3:2, 6:5
// [RULE10] Polarity bits 4 and 7, default falling
// [RULE11] Mode bit: measurement default, delay pulse alternative
// [RULE12] Discharge bit grounds circuit while set
// [RULE13] Unit enable bit 7 turns unit on and off
// [RULE14] Edge flags at low register bits 1:0
// [RULE15] Edge inputs enable bit 3 arms both edges
// [RULE16] Sources: pins, first timer, first compare unit
// [RULE17] Delay mode works with comparator two
// [RULE18] Measurement mode connects current to converter
// [RULE19] Enabled edges of set polarity set flags
`timescale 1ns/10ps
module charge_time_unit (
   input wire logic mclk,
   input wire logic reset,
   input wire logic ce,
   input wire charge_time_pkg::addr_t reg_addr,
   input wire charge_time_pkg::byte_t reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output charge_time_pkg::byte_t reg_rdata,
   input wire logic edge_pin_one,
   input wire logic edge_pin_two,
   input wire logic timer_edge,
   input wire logic compare_edge,
   input wire logic comparator_two_out,
   output charge_time_pkg::analog_ctrl_s analog_ctrl,
   output logic irq
);

   // Number of asynchronous inputs brought through synchronisers
   localparam int unsigned NUM_ASYNC = 3;
   // Number of edge channels
   localparam int unsigned NUM_EDGES = 2;

   // Register state
   charge_time_pkg::ctrl_high_s ctrl_high;
   charge_time_pkg::ctrl_low_s ctrl_low;
   charge_time_pkg::current_s current_ctrl;
   charge_time_pkg::byte_t periph_irq_flags_three;
   charge_time_pkg::byte_t periph_irq_enables_three;

   // Next values of the registers
   charge_time_pkg::ctrl_high_s next_ctrl_high;
   charge_time_pkg::ctrl_low_s next_ctrl_low;
   charge_time_pkg::current_s next_current_ctrl;
   charge_time_pkg::byte_t next_irq_flags;
   charge_time_pkg::byte_t next_irq_enables;

   // Synchroniser stages for pins and comparator
   logic [NUM_ASYNC-1:0] async_in;
   logic [NUM_ASYNC-1:0] sync_first;
   logic [NUM_ASYNC-1:0] sync_second;
   // Comparator level one cycle back, for its rising edge
   logic comp_prev;

   // Edge detector results
   logic [NUM_EDGES-1:0] edge_pulse;
   logic [1:0] edge_sel [NUM_EDGES];
   logic [NUM_EDGES-1:0] edge_pol;

   // Register port decode
   logic wr_high;
   logic wr_low;
   logic wr_current;
   logic wr_irq_flags;
   logic wr_irq_enables;
   charge_time_pkg::byte_t read_mux;

   // Edge flag control
   logic edges_armed;
   logic set_one;
   logic set_two_raw;
   logic set_two;
   logic comp_rise;
   logic next_flag_one;
   logic next_flag_two;

   // Current source and interrupt event
   logic next_current_on;
   logic current_off_event;
   charge_time_pkg::byte_t irq_clear;
   charge_time_pkg::byte_t irq_set;
   logic next_irq;
   charge_time_pkg::analog_ctrl_s next_analog;

   // Pins and comparator come from outside the mclk domain
   assign async_in = {comparator_two_out, edge_pin_two, edge_pin_one};

   // Two-flop synchronisers; first stage feeds only the second
   always_ff @(posedge mclk) begin
      if (reset) begin
         sync_first <= '0;
         sync_second <= '0;
      end else if (ce) begin
         sync_first <= async_in;
         sync_second <= sync_first;
      end
   end

   // Comparator history for the delay-mode stop edge
   always_ff @(posedge mclk) begin
      if (reset) begin
         comp_prev <= 1'b0;
      end else if (ce) begin
         comp_prev <= sync_second[2];
      end
   end

   // Per-edge select and polarity from the low control register
   assign edge_sel[0] = ctrl_low.edge_one_source_sel; // [RULE9]
   assign edge_sel[1] = ctrl_low.edge_two_source_sel; // [RULE9]
   assign edge_pol[0] = ctrl_low.edge_one_polarity; // [RULE10]
   assign edge_pol[1] = ctrl_low.edge_two_polarity; // [RULE10]

   // One detector per edge; select 3 picks the other edge's pin
   genvar gi;
   generate
      for (gi = 0; gi < NUM_EDGES; gi++) begin : g_edge
         // Source vector in select-code order
         logic [3:0] sources;
         assign sources[charge_time_pkg::SRC_OWN_PIN] = sync_second[gi]; // [RULE16]
         assign sources[charge_time_pkg::SRC_TIMER] = timer_edge; // [RULE16]
         assign sources[charge_time_pkg::SRC_COMPARE] = compare_edge; // [RULE16]
         assign sources[charge_time_pkg::SRC_OTHER_PIN] = sync_second[NUM_EDGES-1-gi];
         edge_source_detect u_detect (
            .mclk(mclk),
            .reset(reset),
            .ce(ce),
            .sources(sources),
            .source_sel(edge_sel[gi]),
            .polarity(edge_pol[gi]),
            .edge_pulse(edge_pulse[gi])
         );
      end
   endgenerate

   // Register write decode
   assign wr_high = reg_write & (reg_addr == charge_time_pkg::ADDR_CTRL_HIGH);
   assign wr_low = reg_write & (reg_addr == charge_time_pkg::ADDR_CTRL_LOW);
   assign wr_current = reg_write & (reg_addr == charge_time_pkg::ADDR_CURRENT);
   assign wr_irq_flags = reg_write & (reg_addr == charge_time_pkg::ADDR_IRQ_FLAGS);
   assign wr_irq_enables = reg_write & (reg_addr == charge_time_pkg::ADDR_IRQ_ENABLES);

   // Edges act only with the unit on and inputs armed
   assign edges_armed = ctrl_high.unit_enable & ctrl_high.edge_inputs_enable; // [RULE13] [RULE15]

   // Edge one flag source
   assign set_one = edges_armed & edge_pulse[0]; // [RULE19]

   // Comparator trip ends the pulse in delay mode
   assign comp_rise = sync_second[2] & ~comp_prev;
   assign set_two_raw = edges_armed & (edge_pulse[1] | (ctrl_high.delay_mode_sel & comp_rise)); // [RULE17]

   // With ordering on, edge two waits for edge one
   assign set_two = set_two_raw & (~ctrl_high.edge_order_enable | ctrl_low.edge_one_flag); // [RULE7] [RULE19]

   // Software writes the flags; a hardware set wins over a write clear
   assign next_flag_one = set_one | (wr_low ? reg_wdata[0] : ctrl_low.edge_one_flag); // [RULE3] [RULE14]
   assign next_flag_two = set_two | (wr_low ? reg_wdata[1] : ctrl_low.edge_two_flag); // [RULE3] [RULE14]

   // Low control: polarity and selects from the write, flags as above
   always_comb begin
      next_ctrl_low = ctrl_low;
      // Field update on a write
      if (wr_low) begin
         next_ctrl_low = charge_time_pkg::ctrl_low_s'(reg_wdata); // [RULE9] [RULE10]
      end
      next_ctrl_low.edge_one_flag = next_flag_one;
      next_ctrl_low.edge_two_flag = next_flag_two;
   end

   // High control keeps only implemented bits
   assign next_ctrl_high = wr_high
      ? charge_time_pkg::ctrl_high_s'(reg_wdata & charge_time_pkg::CTRL_HIGH_MASK)
      : ctrl_high; // [RULE7] [RULE11] [RULE12] [RULE13] [RULE15]

   // Current range and trim are plain storage
   assign next_current_ctrl = wr_current ? charge_time_pkg::current_s'(reg_wdata) : current_ctrl; // [RULE8]

   // Current flows while the unit is on and exactly one flag is set
   assign next_current_on = next_ctrl_high.unit_enable & (next_flag_one ^ next_flag_two); // [RULE1] [RULE3]

   // The interrupt event is the source turning off after being on
   assign current_off_event = analog_ctrl.current_on & ~next_current_on; // [RULE4]

   // Interrupt flag: write one to clear, event set wins
   assign irq_clear = wr_irq_flags ? (reg_wdata & charge_time_pkg::IRQ_MASK) : charge_time_pkg::RESET_IRQ;
   assign irq_set = current_off_event ? charge_time_pkg::IRQ_MASK : charge_time_pkg::RESET_IRQ;
   assign next_irq_flags = (periph_irq_flags_three & ~irq_clear) | irq_set; // [RULE4]

   // Interrupt enable, same layout as the flag register
   assign next_irq_enables = wr_irq_enables
      ? (reg_wdata & charge_time_pkg::IRQ_MASK)
      : periph_irq_enables_three;

   // Request only where flag and enable meet
   assign next_irq = |(next_irq_flags & next_irq_enables); // [RULE5]

   // Analog controls, all registered for clean outputs
   always_comb begin
      next_analog = charge_time_pkg::ANALOG_IDLE;
      next_analog.current_on = next_current_on; // [RULE1]
      // Grounding holds as long as the bit is set
      next_analog.discharge = next_ctrl_high.discharge_enable; // [RULE12]
      // Measurement mode hands the current to the converter
      next_analog.adc_connect = next_ctrl_high.unit_enable & ~next_ctrl_high.delay_mode_sel; // [RULE11] [RULE18]
      // Delay mode hands it to comparator two instead
      next_analog.comp_connect = next_ctrl_high.unit_enable & next_ctrl_high.delay_mode_sel; // [RULE11] [RULE17]
      next_analog.current_range_sel = next_current_ctrl.current_range_sel; // [RULE8]
      next_analog.current_trim = next_current_ctrl.current_trim; // [RULE8]
   end

   // Read mux; unmapped words read as zero
   always_comb begin
      unique case (reg_addr)
         charge_time_pkg::ADDR_CTRL_HIGH: read_mux = ctrl_high;
         charge_time_pkg::ADDR_CTRL_LOW: read_mux = ctrl_low; // [RULE6]
         charge_time_pkg::ADDR_CURRENT: read_mux = current_ctrl;
         charge_time_pkg::ADDR_IRQ_FLAGS: read_mux = periph_irq_flags_three;
         charge_time_pkg::ADDR_IRQ_ENABLES: read_mux = periph_irq_enables_three;
         default: read_mux = charge_time_pkg::READ_IDLE;
      endcase
   end

   // Control registers; all fields clear at reset
   always_ff @(posedge mclk) begin
      if (reset) begin
         ctrl_high <= charge_time_pkg::RESET_CTRL_HIGH; // [RULE7] [RULE11]
         ctrl_low <= charge_time_pkg::RESET_CTRL_LOW; // [RULE10]
         current_ctrl <= charge_time_pkg::RESET_CURRENT;
      end else if (ce) begin
         ctrl_high <= next_ctrl_high;
         ctrl_low <= next_ctrl_low;
         current_ctrl <= next_current_ctrl;
      end
   end

   // Interrupt flag and enable registers
   always_ff @(posedge mclk) begin
      if (reset) begin
         periph_irq_flags_three <= charge_time_pkg::RESET_IRQ;
         periph_irq_enables_three <= charge_time_pkg::RESET_IRQ;
      end else if (ce) begin
         periph_irq_flags_three <= next_irq_flags;
         periph_irq_enables_three <= next_irq_enables;
      end
   end

   // Registered outputs toward analog side and interrupt line
   always_ff @(posedge mclk) begin
      if (reset) begin
         analog_ctrl <= charge_time_pkg::ANALOG_IDLE;
         irq <= 1'b0;
      end else if (ce) begin
         analog_ctrl <= next_analog;
         irq <= next_irq;
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge mclk) begin
      if (reset) begin
         reg_rdata <= charge_time_pkg::READ_IDLE;
      end else if (ce) begin
         reg_rdata <= reg_read ? read_mux : charge_time_pkg::READ_IDLE;
      end
   end

endmodule // charge_time_unit

/* logic/edge_source_detect.sv */
// Purpose: Picks one edge source and flags a transition of a polarity
// Assumes: All sources already in the mclk domain
// Notes: Pulse is combinational from the held previous level
`timescale 1ns/10ps
module edge_source_detect (
   input wire logic mclk,
   input wire logic reset,
   input wire logic ce,
   input wire logic [3:0] sources,
   input wire logic [1:0] source_sel,
   input wire logic polarity,
   output logic edge_pulse
);

   // Currently selected source level
   logic chosen;
   // Level seen one cycle earlier
   logic chosen_prev;
   // Rising and falling transitions
   logic rose;
   logic fell;

   // Source mux, indexed by the select code
   assign chosen = sources[source_sel];
   assign rose = chosen & ~chosen_prev;
   assign fell = ~chosen & chosen_prev;
   // Falling polarity is the reset default
   assign edge_pulse = (polarity == charge_time_pkg::POL_FALLING) ? fell : rose;

   // Previous level, frozen with the clock enable
   always_ff @(posedge mclk) begin
      if (reset) begin
         chosen_prev <= 1'b0;
      end else if (ce) begin
         chosen_prev <= chosen;
      end
   end

endmodule // edge_source_detect

/* pkg/charge_time_pkg.sv */
// Purpose: Shared constants and carriers of the charge time unit
// Assumes: 8-bit registers on a plain strobe port, one clock
// Notes: Register word indices are local choices, see hand-over
package charge_time_pkg;

   // Register port widths
   typedef logic [2:0] addr_t;
   typedef logic [7:0] byte_t;

   // Register word indices
   localparam addr_t ADDR_CTRL_HIGH = 3'h0;
   localparam addr_t ADDR_CTRL_LOW = 3'h1;
   localparam addr_t ADDR_CURRENT = 3'h2;
   localparam addr_t ADDR_IRQ_FLAGS = 3'h3;
   localparam addr_t ADDR_IRQ_ENABLES = 3'h4;

   // Reset values, all fields clear
   localparam byte_t RESET_CTRL_HIGH = 8'h00;
   localparam byte_t RESET_CTRL_LOW = 8'h00;
   localparam byte_t RESET_CURRENT = 8'h00;
   localparam byte_t RESET_IRQ = 8'h00;

   // Implemented bits of each register
   localparam byte_t CTRL_HIGH_MASK = 8'h9E;
   localparam byte_t IRQ_MASK = 8'h04;
   localparam byte_t READ_IDLE = 8'h00;

   // High control layout
   typedef struct packed {
      logic unit_enable;
      logic [1:0] unused_hi;
      logic delay_mode_sel;
      logic edge_inputs_enable;
      logic edge_order_enable;
      logic discharge_enable;
      logic unused_lo;
   } ctrl_high_s;

   // Low control layout
   typedef struct packed {
      logic edge_two_polarity;
      logic [1:0] edge_two_source_sel;
      logic edge_one_polarity;
      logic [1:0] edge_one_source_sel;
      logic edge_two_flag;
      logic edge_one_flag;
   } ctrl_low_s;

   // Current source control layout
   typedef struct packed {
      logic [5:0] current_trim;
      logic [1:0] current_range_sel;
   } current_s;

   // Edge source select codes
   localparam logic [1:0] SRC_OWN_PIN = 2'h0;
   localparam logic [1:0] SRC_TIMER = 2'h1;
   localparam logic [1:0] SRC_COMPARE = 2'h2;
   localparam logic [1:0] SRC_OTHER_PIN = 2'h3;

   // Polarity code for a high-to-low edge
   localparam logic POL_FALLING = 1'b0;

   // Controls toward the analog side
   typedef struct packed {
      logic current_on;
      logic discharge;
      logic adc_connect;
      logic comp_connect;
      logic [1:0] current_range_sel;
      logic [5:0] current_trim;
   } analog_ctrl_s;

   // Reset value of the analog controls
   localparam analog_ctrl_s ANALOG_IDLE = '0;

endpackage
